//--- timer_host_defs.svh
// constants and behaviour notes for the complementary pwm / phase counting timer host
// Notes on behaviour
// - Software halts both channel-3 and channel-4 counters before selecting complementary mode.
// - Channels 3 and 4 get identical clock source and edge, no clear source.
// - Channel-4 counter cleared to zero, channel-3 loaded with offset; never equal.
// - Period register holds half cycle plus offset minus two; transitions not below offset.
// - No general register value below the offset before the first match A.
// - Duty changes during operation go through buffer registers, not direct writes.
// - Transfer at up-to-down turnaround never crosses the range period-T+1..period.
// - Transfer at down-to-up turnaround never crosses the range 0..T-1.
// - Out-of-range value and its return into range are written in one direction.
// - Phase counting: set mode bit, pick flag direction, then start channel 2.
// - Phase inputs keep 1.5 cycles phase difference and 2.5 cycles pulse width.
`ifndef TIMER_HOST_DEFS_SVH
`define TIMER_HOST_DEFS_SVH
// apb register offsets
`define TH_ADDR_CTRL      8'h00
`define TH_ADDR_CYCLE     8'h04
`define TH_ADDR_DEAD      8'h08
`define TH_ADDR_DUTY0     8'h0C
`define TH_ADDR_DUTY1     8'h10
`define TH_ADDR_DUTY2     8'h14
`define TH_ADDR_STEPS     8'h18
`define TH_ADDR_STATUS    8'h1C
// control register bit positions
`define TH_CTRL_PWM       0
`define TH_CTRL_PHASE     1
`define TH_CTRL_STOP      2
`define TH_CTRL_DIR       3
`define TH_CTRL_FLAG_DIRECTION_BIT      4
// device register field values
`define TH_RUN_CH2        2
`define TH_RUN_CH3        3
`define TH_RUN_CH4        4
`define TH_MODE_FLAG_DIRECTION_BIT      5
`define TH_MODE_PHASE     6
`define TH_COMBINED_COMP  16'h0002
`define TH_PERIOD_ADJ     16'h0002
`define TH_ZERO16         16'h0000
`define TH_ZERO32         32'h0000_0000
`endif

//--- timer_host_pkg.sv
// types shared by the timer host modules
package timer_host_pkg;
  // device registers the host can address through its write port
  typedef enum logic [3:0] {
    DEV_START    = 4'h0,
    DEV_CTRL3    = 4'h1,
    DEV_CTRL4    = 4'h2,
    DEV_COMBINED = 4'h3,
    DEV_MODE     = 4'h4,
    DEV_CNT3     = 4'h5,
    DEV_CNT4     = 4'h6,
    DEV_PERIOD   = 4'h7,
    DEV_TR1      = 4'h8,
    DEV_TR2      = 4'h9,
    DEV_TR3      = 4'hA,
    DEV_BUF1     = 4'hB,
    DEV_BUF2     = 4'hC,
    DEV_BUF3     = 4'hD
  } devreg_e;
  typedef enum logic [4:0] {
    S_IDLE    = 5'h00,
    S_HALT    = 5'h01,
    S_CLK3    = 5'h03,
    S_CLK4    = 5'h02,
    S_MODE    = 5'h06,
    S_CNT4    = 5'h07,
    S_CNT3    = 5'h05,
    S_PER     = 5'h04,
    S_TR      = 5'h0C,
    S_START   = 5'h0D,
    S_RUN     = 5'h0F,
    S_BUF     = 5'h0E,
    S_PHMODE  = 5'h1E,
    S_PHSTART = 5'h1F,
    S_QUAD    = 5'h1D
  } state_e;
endpackage

//--- quad_step_gen.sv
// quadrature phase pair generator for the channel-2 phase counting inputs
`include "timer_host_defs.svh"
module quad_step_gen #(
  parameter int STEP_GAP = 4
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // command
  input  wire logic        start,
  input  wire logic [15:0] steps,
  input  wire logic        countUp,
  output      logic        busy,
  // encoder pins
  output      logic        phaseInputA,
  output      logic        phaseInputB
);
  // STEP_GAP core cycles between edges, at least two, keep 1.5 and 2.5 cycle margins at the device
  initial
  begin
    if (STEP_GAP < 2 || STEP_GAP > 255)
      $error("quad_step_gen: STEP_GAP out of range");
  end

  localparam logic [7:0] GAP = 8'(STEP_GAP - 1);
  logic [15:0] remaining;
  logic [7:0]  gapCnt;
  logic        dirUp;

  assign busy = (remaining != `TH_ZERO16);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      remaining <= `TH_ZERO16;
      gapCnt    <= 8'h00;
      dirUp     <= 1'b1;
    end
    else if (start && !busy)
    begin
      remaining <= steps;
      gapCnt    <= GAP;
      dirUp     <= countUp;
    end
    else if (busy)
    begin
      if (gapCnt == 8'h00)
      begin
        remaining <= remaining - 16'h0001;
        gapCnt    <= GAP;
      end
      else
        gapCnt <= gapCnt - 8'h01;
    end
  end

  // up: A==B toggles B, else A; down is the mirror
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      phaseInputA <= 1'b0;
      phaseInputB <= 1'b0;
    end
    else if (busy && gapCnt == 8'h00)
    begin
      if ((phaseInputA == phaseInputB) == dirUp)
        phaseInputB <= ~phaseInputB;
      else
        phaseInputA <= ~phaseInputA;
    end
  end

  // helper: cycles since the last edge on either pin
  logic [7:0] sinceEdge;
  always_ff @(posedge core_clk)
  begin
    if (rst)
      sinceEdge <= 8'hFF;
    else if (busy && gapCnt == 8'h00)
      sinceEdge <= 8'h00;
    else if (sinceEdge != 8'hFF)
      sinceEdge <= sinceEdge + 8'h01;
  end

  property p_edge_gap;
    @(posedge core_clk) disable iff (rst)
    ($changed(phaseInputA) || $changed(phaseInputB)) |-> ($past(sinceEdge) >= GAP);
  endproperty
  a_edge_gap: assert property (p_edge_gap) else $error("phase edges too close");

  property p_one_pin;
    @(posedge core_clk) disable iff (rst)
    $changed(phaseInputA) |-> $stable(phaseInputB);
  endproperty
  a_one_pin: assert property (p_one_pin) else $error("both phase pins moved at once");
endmodule

//--- pwm_phase_host.sv
// apb controlled host that programs and drives the complementary pwm / phase timer
`include "timer_host_defs.svh"
module pwm_phase_host #(
  parameter logic [4:0] CLOCK_SELECT = 5'h00,
  parameter int         STEP_GAP     = 4
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // device register write port
  output      logic        devWe,
  output      logic [3:0]  devSel,
  output      logic [15:0] devData,
  input  wire logic        devReady,
  // device events
  input  wire logic        matchAFlag,
  input  wire logic        overflowFlag,
  // encoder pins
  output      logic        phaseInputA,
  output      logic        phaseInputB
);
  initial
  begin
    if (STEP_GAP < 2)
      $error("pwm_phase_host: STEP_GAP below 2");
  end

  timer_host_pkg::state_e state;
  timer_host_pkg::state_e next_state;
  logic [15:0] cycleCount;
  logic [15:0] deadCount;
  logic [15:0] duty [3];
  logic [15:0] applied [3];
  logic [15:0] steps;
  logic        countUp;
  logic        flagDir;
  logic        goPwm;
  logic        goPhase;
  logic        goStop;
  logic        pending;
  logic        setupErr;
  logic        seenMatch;
  logic [1:0]  idx;
  logic        quadStart;
  logic        quadBusy;
  logic [15:0] period;
  logic        isWrite;
  logic [15:0] next_data;
  timer_host_pkg::devreg_e next_sel;

  // apb: zero wait states; unmapped offsets answer with an error
  logic apbWr;
  logic mapped;
  assign pready  = 1'b1;
  assign apbWr   = psel && penable && pwrite;
  assign mapped  = (paddr[1:0] == 2'b00) && (paddr <= `TH_ADDR_STATUS);
  assign pslverr = psel && penable && !mapped;
  assign period  = 16'((cycleCount >> 1) + deadCount - `TH_PERIOD_ADJ);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cycleCount <= `TH_ZERO16;
      deadCount  <= `TH_ZERO16;
      steps      <= `TH_ZERO16;
      countUp    <= 1'b1;
      flagDir    <= 1'b0;
    end
    else if (apbWr && mapped)
    begin
      case (paddr)
        `TH_ADDR_CTRL:
        begin
          countUp <= pwdata[`TH_CTRL_DIR];
          flagDir <= pwdata[`TH_CTRL_FLAG_DIRECTION_BIT];
        end
        `TH_ADDR_CYCLE: cycleCount <= pwdata[15:0];
        `TH_ADDR_DEAD:  deadCount  <= pwdata[15:0];
        `TH_ADDR_STEPS: steps      <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_duty
      always_ff @(posedge core_clk)
      begin
        if (rst)
          duty[g] <= `TH_ZERO16;
        else if (apbWr && paddr == 8'(`TH_ADDR_DUTY0 + 4 * g))
          duty[g] <= pwdata[15:0];
      end
    end
  endgenerate

  // command strobes are latched from the control write; held until the state machine can take them
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      goPwm   <= 1'b0;
      goPhase <= 1'b0;
      goStop  <= 1'b0;
    end
    else
    begin
      // start is held through the halt write so that it still picks the setup path there
      goPwm   <= (apbWr && paddr == `TH_ADDR_CTRL) ? pwdata[`TH_CTRL_PWM]
                 : (goPwm && !(state == timer_host_pkg::S_CLK3)
                    && !(state == timer_host_pkg::S_IDLE && deadCount == `TH_ZERO16));
      goPhase <= (apbWr && paddr == `TH_ADDR_CTRL) ? pwdata[`TH_CTRL_PHASE]
                 : (goPhase && !(state == timer_host_pkg::S_IDLE));
      goStop  <= (apbWr && paddr == `TH_ADDR_CTRL) ? pwdata[`TH_CTRL_STOP]
                 : (goStop && !(state == timer_host_pkg::S_RUN));
    end
  end

  always_comb
  begin
    prdata = `TH_ZERO32;
    if (psel && !pwrite)
    begin
      case (paddr)
        `TH_ADDR_CTRL:   prdata = {27'h0, flagDir, countUp, 3'b000};
        `TH_ADDR_CYCLE:  prdata = {16'h0, cycleCount};
        `TH_ADDR_DEAD:   prdata = {16'h0, deadCount};
        `TH_ADDR_DUTY0:  prdata = {16'h0, duty[0]};
        `TH_ADDR_DUTY1:  prdata = {16'h0, duty[1]};
        `TH_ADDR_DUTY2:  prdata = {16'h0, duty[2]};
        `TH_ADDR_STEPS:  prdata = {16'h0, steps};
        `TH_ADDR_STATUS: prdata = {22'h0, quadBusy, seenMatch, setupErr, pending, 1'b0, state};
        default:         prdata = `TH_ZERO32;
      endcase
    end
  end

  // range checks for a buffered update against the value already in use
  function automatic logic upd_ok(input logic [15:0] n, input logic [15:0] o, input logic [15:0] per,
                                  input logic [15:0] t, input logic atMatch);
    logic outside;
    logic lowN;
    logic lowO;
    logic hiN;
    logic hiO;
    outside = (n > per) || (o > per);
    lowN    = (n < t);
    lowO    = (o < t);
    hiN     = (n <= per) && (n > 16'(per - t));
    hiO     = (o <= per) && (o > 16'(per - t));
    if (outside)
      upd_ok = atMatch;
    else if (atMatch)
      upd_ok = (hiN == hiO);
    else
      upd_ok = (lowN == lowO);
  endfunction

  logic evt;
  logic allowAll;
  assign evt      = matchAFlag || overflowFlag;
  assign allowAll = upd_ok(duty[0], applied[0], period, deadCount, matchAFlag)
                    && upd_ok(duty[1], applied[1], period, deadCount, matchAFlag)
                    && upd_ok(duty[2], applied[2], period, deadCount, matchAFlag);

  // pending: software write wins over the hardware clear in the same cycle
  logic dutyWr;
  assign dutyWr = apbWr && (paddr == `TH_ADDR_DUTY0 || paddr == `TH_ADDR_DUTY1 || paddr == `TH_ADDR_DUTY2);
  always_ff @(posedge core_clk)
  begin
    if (rst)
      pending <= 1'b0;
    else if (dutyWr)
      pending <= 1'b1;
    else if (state == timer_host_pkg::S_RUN && evt && allowAll && seenMatch)
      pending <= 1'b0;
  end

  always_comb
  begin
    next_sel   = timer_host_pkg::DEV_START;
    next_data  = `TH_ZERO16;
    isWrite    = 1'b1;
    next_state = state;
    case (state)
      timer_host_pkg::S_HALT:
      begin
        next_state = goPwm ? timer_host_pkg::S_CLK3 : timer_host_pkg::S_IDLE;
      end
      timer_host_pkg::S_CLK3:
      begin
        next_sel   = timer_host_pkg::DEV_CTRL3;
        next_data  = 16'(CLOCK_SELECT);
        next_state = timer_host_pkg::S_CLK4;
      end
      timer_host_pkg::S_CLK4:
      begin
        next_sel   = timer_host_pkg::DEV_CTRL4;
        next_data  = 16'(CLOCK_SELECT);
        next_state = timer_host_pkg::S_MODE;
      end
      timer_host_pkg::S_MODE:
      begin
        next_sel   = timer_host_pkg::DEV_COMBINED;
        next_data  = `TH_COMBINED_COMP;
        next_state = timer_host_pkg::S_CNT4;
      end
      timer_host_pkg::S_CNT4:
      begin
        next_sel   = timer_host_pkg::DEV_CNT4;
        next_data  = `TH_ZERO16;
        next_state = timer_host_pkg::S_CNT3;
      end
      timer_host_pkg::S_CNT3:
      begin
        next_sel   = timer_host_pkg::DEV_CNT3;
        next_data  = deadCount;
        next_state = timer_host_pkg::S_PER;
      end
      timer_host_pkg::S_PER:
      begin
        next_sel   = timer_host_pkg::DEV_PERIOD;
        next_data  = period;
        next_state = timer_host_pkg::S_TR;
      end
      timer_host_pkg::S_TR:
      begin
        next_sel   = timer_host_pkg::devreg_e'(4'(timer_host_pkg::DEV_TR1 + idx));
        next_data  = (duty[idx] < deadCount) ? deadCount : duty[idx];
        next_state = (idx == 2'd2) ? timer_host_pkg::S_START : timer_host_pkg::S_TR;
      end
      timer_host_pkg::S_START:
      begin
        next_data  = 16'((16'h1 << `TH_RUN_CH3) | (16'h1 << `TH_RUN_CH4));
        next_state = timer_host_pkg::S_RUN;
      end
      timer_host_pkg::S_BUF:
      begin
        next_sel   = timer_host_pkg::devreg_e'(4'(timer_host_pkg::DEV_BUF1 + idx));
        next_data  = applied[idx];
        next_state = (idx == 2'd2) ? timer_host_pkg::S_RUN : timer_host_pkg::S_BUF;
      end
      timer_host_pkg::S_PHMODE:
      begin
        next_sel   = timer_host_pkg::DEV_MODE;
        next_data  = 16'((16'h1 << `TH_MODE_PHASE) | (16'(flagDir) << `TH_MODE_FLAG_DIRECTION_BIT));
        next_state = timer_host_pkg::S_PHSTART;
      end
      timer_host_pkg::S_PHSTART:
      begin
        next_data  = 16'(16'h1 << `TH_RUN_CH2);
        next_state = timer_host_pkg::S_QUAD;
      end
      default:
        isWrite = 1'b0;
    endcase
  end

  // each device write: load select/data, raise the strobe, hold until devReady
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state     <= timer_host_pkg::S_IDLE;
      devWe     <= 1'b0;
      devSel    <= 4'h0;
      devData   <= `TH_ZERO16;
      idx       <= 2'd0;
      setupErr  <= 1'b0;
      quadStart <= 1'b0;
    end
    else
    begin
      quadStart <= 1'b0;
      if (isWrite)
      begin
        if (!devWe)
        begin
          devWe   <= 1'b1;
          devSel  <= next_sel;
          devData <= next_data;
        end
        else if (devReady)
        begin
          devWe <= 1'b0;
          idx   <= (next_state == state) ? 2'(idx + 2'd1) : 2'd0;
          state <= next_state;
          if (state == timer_host_pkg::S_PHSTART)
            quadStart <= 1'b1;
        end
      end
      else
      begin
        case (state)
          timer_host_pkg::S_IDLE:
          begin
            idx <= 2'd0;
            if (goPwm)
            begin
              // a zero offset would put both counters on the same value
              setupErr <= (deadCount == `TH_ZERO16);
              if (deadCount != `TH_ZERO16)
                state <= timer_host_pkg::S_HALT;
            end
            else if (goPhase)
              state <= timer_host_pkg::S_PHMODE;
          end
          timer_host_pkg::S_RUN:
          begin
            if (goStop)
              state <= timer_host_pkg::S_HALT;
            else if (pending && evt && allowAll && seenMatch)
              state <= timer_host_pkg::S_BUF;
          end
          timer_host_pkg::S_QUAD:
          begin
            if (!quadBusy && !quadStart)
              state <= timer_host_pkg::S_IDLE;
          end
          default:
            state <= timer_host_pkg::S_IDLE;
        endcase
      end
    end
  end

  // in-use values: floored copy at start, buffered copy at each accepted update
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      seenMatch <= 1'b0;
      for (int i = 0; i < 3; i++)
        applied[i] <= `TH_ZERO16;
    end
    else if (state == timer_host_pkg::S_START)
    begin
      seenMatch <= 1'b0;
      for (int i = 0; i < 3; i++)
        applied[i] <= (duty[i] < deadCount) ? deadCount : duty[i];
    end
    else if (state == timer_host_pkg::S_RUN)
    begin
      if (matchAFlag)
        seenMatch <= 1'b1;
      if (pending && evt && allowAll && seenMatch && !goStop)
        for (int i = 0; i < 3; i++)
          applied[i] <= duty[i];
    end
  end

  quad_step_gen #(
    .STEP_GAP (STEP_GAP)
  ) u_quad (
    .core_clk    (core_clk),
    .rst         (rst),
    .start       (quadStart),
    .steps       (steps),
    .countUp     (countUp),
    .busy        (quadBusy),
    .phaseInputA (phaseInputA),
    .phaseInputB (phaseInputB)
  );

  property p_halt_zero;
    @(posedge core_clk) disable iff (rst)
    (devWe && state == timer_host_pkg::S_HALT) |-> (devData == `TH_ZERO16);
  endproperty
  a_halt_zero: assert property (p_halt_zero) else $error("halt write not zero");

  property p_same_clock;
    @(posedge core_clk) disable iff (rst)
    (devWe && devReady && devSel == 4'(timer_host_pkg::DEV_CTRL3)) |=> ##[1:2]
      (devWe && devSel == 4'(timer_host_pkg::DEV_CTRL4) && devData == $past(devData, 2));
  endproperty
  a_same_clock: assert property (p_same_clock) else $error("ch4 clock differs from ch3");

  property p_cnt_order;
    @(posedge core_clk) disable iff (rst)
    (devWe && devSel == 4'(timer_host_pkg::DEV_CNT3)) |-> (devData != `TH_ZERO16 && devData == deadCount);
  endproperty
  a_cnt_order: assert property (p_cnt_order) else $error("ch3 counter load equals ch4");

  property p_period;
    @(posedge core_clk) disable iff (rst)
    (devWe && devSel == 4'(timer_host_pkg::DEV_PERIOD))
      |-> (devData == 16'((cycleCount >> 1) + deadCount - 16'h0002));
  endproperty
  a_period: assert property (p_period) else $error("period value wrong");

  property p_tr_floor;
    @(posedge core_clk) disable iff (rst)
    (devWe && state == timer_host_pkg::S_TR) |-> (devData >= deadCount);
  endproperty
  a_tr_floor: assert property (p_tr_floor) else $error("transition below offset");

  property p_buf_on_event;
    @(posedge core_clk) disable iff (rst)
    $rose(state == timer_host_pkg::S_BUF) |-> $past(matchAFlag || overflowFlag);
  endproperty
  a_buf_on_event: assert property (p_buf_on_event) else $error("buffer update without turnaround");

  property p_hold;
    @(posedge core_clk) disable iff (rst)
    (devWe && !devReady) |=> (devWe && $stable(devData) && $stable(devSel));
  endproperty
  a_hold: assert property (p_hold) else $error("device write dropped early");

  property p_phase_start;
    @(posedge core_clk) disable iff (rst)
    $rose(state == timer_host_pkg::S_PHSTART) |->
      $past(devWe && devReady && devSel == 4'(timer_host_pkg::DEV_MODE) && devData[`TH_MODE_PHASE]);
  endproperty
  a_phase_start: assert property (p_phase_start) else $error("channel 2 started out of order");
endmodule

//--- timer_device_model.sv
// behavioural model of the timer device behind the host
module timer_device_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // host write port
  input  wire logic        devWe,
  input  wire logic [3:0]  devSel,
  input  wire logic [15:0] devData,
  output      logic        devReady,
  // bench controls
  input  wire logic        slow,
  input  wire logic        hitA,
  input  wire logic        hitU,
  // events and encoder
  output      logic        matchAFlag,
  output      logic        overflowFlag,
  input  wire logic        phaseInputA,
  input  wire logic        phaseInputB
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] regs [16];
  logic [3:0]  wrLog [16];
  logic [15:0] wrDat [16];
  int          nWr;
  int          quad;
  int          gap;
  int          minGap;
  logic [1:0]  waitCnt;
  logic        lastA;
  logic        lastB;
  logic        pwmPins;
  logic [2:0]  constDuty;
  // a slow device holds each write off for three cycles
  assign devReady = !slow || waitCnt == 2'h3;
  assign pwmPins = regs[3] == 16'h0002;
  // a phase whose transition lies beyond the period never toggles
  assign constDuty = {regs[10] > regs[7], regs[9] > regs[7], regs[8] > regs[7]};
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      waitCnt <= 2'h0;
      nWr <= 0;
      for (int i = 0; i < 16; i++) regs[i] <= 16'h0000;
    end
    else
    begin
      if (devWe && devReady)
      begin
        regs[devSel] <= devData;
        wrLog[nWr[3:0]] <= devSel;
        wrDat[nWr[3:0]] <= devData;
        nWr <= nWr + 1;
        waitCnt <= 2'h0;
      end
      else if (devWe && waitCnt != 2'h3)
        waitCnt <= waitCnt + 2'h1;
      // buffers reach the compare registers only at the turnarounds
      if (matchAFlag || overflowFlag)
        for (int i = 0; i < 3; i++) regs[8 + i] <= regs[11 + i];
    end
  end
  // match flag only while channel 3 runs, overflow flag only while channel 4 runs
  always_ff @(posedge core_clk)
  begin
    matchAFlag <= !rst && hitA && regs[0][3];
    overflowFlag <= !rst && hitU && regs[0][4];
  end
  always_ff @(posedge core_clk)
  begin
    lastA <= phaseInputA;
    lastB <= phaseInputB;
    if (rst)
    begin
      quad <= 0;
      gap <= 0;
      minGap <= 1000;
    end
    else if (phaseInputA != lastA || phaseInputB != lastB)
    begin
      if (regs[4][6] && regs[0][2])
        quad <= quad + ((phaseInputB != lastB ? phaseInputB != phaseInputA : phaseInputA == phaseInputB) ? 1 : -1);
      if (gap + 1 < minGap)
        minGap <= gap + 1;
      gap <= 0;
    end
    else
      gap <= gap + 1;
  end
endmodule

//--- pwm_phase_host_bench.sv
// self-checking bench for the pwm phase host
`include "timer_host_defs.svh"
module pwm_phase_host_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        devWe;
  logic [3:0]  devSel;
  logic [15:0] devData;
  logic        devReady;
  logic        matchAFlag;
  logic        overflowFlag;
  logic        phaseInputA;
  logic        phaseInputB;
  logic        slow;
  logic        hitA;
  logic        hitU;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch;
  int          samples_checked;
  logic [3:0]  expSel [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h5, 4'h7, 4'h8, 4'h9, 4'hA, 4'h0};
  logic [15:0] expDat [11] = '{16'h0000, 16'h0005, 16'h0005, 16'h0002, 16'h0000, 16'h0004, 16'h0034,
                               16'h0004, 16'h0032, 16'h001E, 16'h0018};
  pwm_phase_host #(.CLOCK_SELECT(5'h05), .STEP_GAP(4)) pwm_phase_host_i (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .devWe(devWe), .devSel(devSel), .devData(devData),
    .devReady(devReady), .matchAFlag(matchAFlag), .overflowFlag(overflowFlag),
    .phaseInputA(phaseInputA), .phaseInputB(phaseInputB));
  timer_device_model timer_device_model_i (.core_clk(core_clk), .rst(rst), .devWe(devWe), .devSel(devSel),
    .devData(devData), .devReady(devReady), .slow(slow), .hitA(hitA), .hitU(hitU),
    .matchAFlag(matchAFlag), .overflowFlag(overflowFlag), .phaseInputA(phaseInputA),
    .phaseInputB(phaseInputB));
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask
  // entered just after a rising edge; leaves just after one
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic pulse(input logic isMatch);
    hitA <= isMatch;
    hitU <= !isMatch;
    @(posedge core_clk);
    hitA <= 1'b0;
    hitU <= 1'b0;
    repeat (40) @(posedge core_clk);
  endtask
  task automatic waitState(input logic [4:0] s);
    repeat (30) @(posedge core_clk);
    do apb(1'b0, `TH_ADDR_STATUS, 32'h0000_0000); while (rd[4:0] !== s);
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    n_mismatch = 0;
    samples_checked = 0;
    {psel, penable, pwrite, slow, hitA, hitU} <= 6'h00;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, `TH_ADDR_STATUS, 32'h0000_0000);
    chk("status after reset", 32'h0000_0000, rd);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
    apb(1'b1, `TH_ADDR_CTRL, 32'h0000_0001);
    apb(1'b0, `TH_ADDR_STATUS, 32'h0000_0000);
    chk("zero offset refused", 32'h0000_0080, rd);
    apb(1'b1, `TH_ADDR_CYCLE, 32'h0000_0064);
    apb(1'b1, `TH_ADDR_DEAD, 32'h0000_0004);
    apb(1'b1, `TH_ADDR_DUTY0, 32'h0000_0002);
    apb(1'b1, `TH_ADDR_DUTY1, 32'h0000_0032);
    apb(1'b1, `TH_ADDR_DUTY2, 32'h0000_001E);
    apb(1'b1, `TH_ADDR_CTRL, 32'h0000_0001);
    waitState(timer_host_pkg::S_RUN);
    for (int i = 0; i < 11; i++)
    begin
      chk("setup select", expSel[i], timer_device_model_i.wrLog[i]);
      chk("setup data", expDat[i], timer_device_model_i.wrDat[i]);
    end
    chk("pwm pins taken", 32'h0000_0001, {31'h0000_0000, timer_device_model_i.pwmPins});
    chk("no constant phase", 32'h0000_0000, {29'h0000_0000, timer_device_model_i.constDuty});
    apb(1'b1, `TH_ADDR_DUTY1, 32'h0000_0031);
    pulse(1'b0);
    chk("buffer before first match", 16'h0000, timer_device_model_i.regs[12]);
    pulse(1'b1);
    pulse(1'b1);
    chk("buffer two update", 16'h0031, timer_device_model_i.regs[12]);
    chk("buffer three update", 16'h001E, timer_device_model_i.regs[13]);
    apb(1'b1, `TH_ADDR_DUTY1, 32'h0000_0028);
    pulse(1'b1);
    chk("high range held at match", 16'h0031, timer_device_model_i.regs[12]);
    pulse(1'b0);
    chk("high range at underflow", 16'h0028, timer_device_model_i.regs[12]);
    apb(1'b1, `TH_ADDR_DUTY0, 32'h0000_000A);
    pulse(1'b0);
    chk("low range held at underflow", 16'h0002, timer_device_model_i.regs[11]);
    pulse(1'b1);
    chk("low range at match", 16'h000A, timer_device_model_i.regs[11]);
    apb(1'b1, `TH_ADDR_CTRL, 32'h0000_0004);
    waitState(timer_host_pkg::S_IDLE);
    chk("stopped", 16'h0000, timer_device_model_i.regs[0]);
    slow <= 1'b1;
    apb(1'b1, `TH_ADDR_STEPS, 32'h0000_0006);
    apb(1'b1, `TH_ADDR_CTRL, 32'h0000_001A);
    waitState(timer_host_pkg::S_IDLE);
    chk("phase mode", 16'h0060, timer_device_model_i.regs[4]);
    chk("phase start", 16'h0004, timer_device_model_i.regs[0]);
    chk("count up", 32'h0000_0006, timer_device_model_i.quad);
    chk("edge spacing", 32'h0000_0001, {31'h0000_0000, timer_device_model_i.minGap >= 2});
    apb(1'b1, `TH_ADDR_CTRL, 32'h0000_0002);
    waitState(timer_host_pkg::S_IDLE);
    chk("count down", 32'h0000_0000, timer_device_model_i.quad);
    wrap_up();
  end
endmodule
